// ### sms_regs.vh
// Purpose: constants shared by the serial controller and its FIFO
// Assumes: 100 MHz system clock, bytes of eight bits
// Notes: definitions only, guarded against double inclusion
`ifndef SMS_REGS_VH
`define SMS_REGS_VH

// Select-mode field encodings
`define SMS_MODE_3WIRE 2'h0
`define SMS_MODE_MULTI 2'h1
`define SMS_MODE_HI_BIT 1
`define SMS_MODE_LO_BIT 0
// Reset values of the control bits
`define SMS_MODE_RESET 2'h1
`define SMS_ENABLE_RESET 1'h0
`define SMS_MASTER_RESET 1'h0

// Byte framing
`define SMS_BYTE_W 8
`define SMS_LAST_BIT 3'h7

// Receive FIFO shape
`define SMS_FIFO_W 8
`define SMS_FIFO_DEPTH 8
`define SMS_FIFO_AW 3

// Timing: master clock half period, least time, rounded up
`define SMS_CLK_NS 10
`define SMS_SCK_HALF_NS 40
`define SMS_SCK_HALF_CYC \
	((`SMS_SCK_HALF_NS + `SMS_CLK_NS - 1) / `SMS_CLK_NS)

`endif

// ### sms_fifo.v
// Purpose: small first-in first-out buffer for received bytes
// Assumes: one clock, synchronous active-high reset
// Notes: all outputs registered, show-ahead read data
`timescale 1ns/1ns
module sms_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire clk,
	input wire rst,
	input wire inValid,
	input wire [WIDTH-1:0] inData,
	output reg inReady,
	output reg outValid,
	output reg [WIDTH-1:0] outData,
	input wire outReady
);

reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW-1:0] wrPtr;
reg [AW-1:0] rdPtr;
reg [AW:0] count;
wire push;
wire pop;
wire [AW-1:0] next_rdPtr;
wire [AW:0] next_count;

// Handshakes use registered ready and valid, so never over or under run
assign push = inValid & inReady;
assign pop = outReady & outValid;
assign next_rdPtr = pop ? rdPtr + 1'b1 : rdPtr;
assign next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

// Storage has no reset; contents are only read once written
always @(posedge clk) begin
	if (push) begin
		mem[wrPtr] <= inData;
	end
end

// Pointers, fill level and registered flags
always @(posedge clk) begin
	if (rst) begin
		wrPtr <= {AW{1'b0}};
		rdPtr <= {AW{1'b0}};
		count <= {(AW+1){1'b0}};
		inReady <= 1'b0;
		outValid <= 1'b0;
		outData <= {WIDTH{1'b0}};
	end else begin
		if (push) begin
			wrPtr <= wrPtr + 1'b1;
		end
		rdPtr <= next_rdPtr;
		count <= next_count;
		inReady <= (next_count != DEPTH[AW:0]);
		outValid <= (next_count != {(AW+1){1'b0}});
		// Bypass when the word being written is the next one shown
		if (push && (wrPtr == next_rdPtr)) begin
			outData <= inData;
		end else begin
			outData <= mem[next_rdPtr];
		end
	end
end

endmodule

// ### sms_ctrl.v
// Purpose: full-duplex serial controller, master or slave, with select modes
// Assumes: clk at 100 MHz, rst synchronous active high, link mode 0
// Notes: pins are split into in, out and active-low output enable
//
// Behaviour
// - Shift every byte most significant bit first
// - Master drives master-out from shift MSB
// - Slave-out tri-stated when disabled or unselected
// - Three-wire slave always drives slave-out MSB
// - Four-wire slave ignores clock while select high
// - Mode 00: three-wire, slave always selected
// - Mode 01: select input, low selects slave
// - Multi-master low select clears enables, sets fault
// - Mode 1x: select output follows low bit
// - Select routed to pin except in three-wire mode 00
// - Master enable flag enters master operation
// - Data write fills buffer, starts if shifter empty; master also waits for receive room
// - Master shifts out at once, makes clock
// - Done flag set at each byte end
// - Received byte moves to receive buffer, MSB first; if full, dropped, overrun flagged
// - Reset select mode is multi-master, input select
// - Slave counts eight edges then completes byte
// - Write while buffer full and not loaded that cycle dropped, collision flagged
`timescale 1ns/1ns
`include "sms_regs.vh"
module sms_ctrl (
	input wire clk,
	input wire rst,
	input wire ctrlWrite,
	input wire ctrlWrEnable,
	input wire ctrlWrMaster,
	input wire [1:0] ctrlWrMode,
	input wire serialDataWrite,
	input wire [7:0] serialDataByte,
	input wire clearDone,
	input wire clearCollision,
	input wire clearFault,
	input wire clearOverrun,
	output wire [7:0] rxByte,
	output wire rxValid,
	input wire rxReady,
	input wire sckIn,
	output reg sckOut,
	output reg sckOeN,
	input wire mosiIn,
	output reg mosiOut,
	output reg mosiOeN,
	input wire misoIn,
	output reg misoOut,
	output reg misoOeN,
	input wire nssIn,
	output reg nssOut,
	output reg nssOeN,
	output reg nssPinMapped,
	output reg serialCtrlEnable,
	output reg masterEnableFlag,
	output reg [1:0] selectModeField,
	output reg transferDoneFlag,
	output reg writeCollisionFlag,
	output reg modeFaultFlag,
	output reg overrunFlag,
	output reg busy,
	output reg txBufFull
);

localparam [1:0] M_IDLE = 2'h0;
localparam [1:0] M_LOW = 2'h1;
localparam [1:0] M_HIGH = 2'h2;
localparam integer HALF_LAST_INT = `SMS_SCK_HALF_CYC - 1;
localparam [3:0] HALF_LAST = HALF_LAST_INT[3:0];

// Sticky flag: an event in the clearing cycle wins over the clear
function flagNext(input cur, input setEv, input clrEv);
	begin
		flagNext = setEv | (cur & ~clrEv);
	end
endfunction

// Slave selection as decoded from the select mode and pin level
function slaveSelected(input [1:0] mode, input nss);
	begin
		slaveSelected = (mode == `SMS_MODE_3WIRE) |
			((mode == `SMS_MODE_MULTI) & ~nss);
	end
endfunction

reg sckMeta;
reg sckSync;
reg sckPrev;
reg mosiMeta;
reg mosiSync;
reg misoMeta;
reg misoSync;
reg nssMeta;
reg nssSync;
reg nssPrev;
reg [7:0] shiftReg;
reg [7:0] txBuf;
reg shiftEmpty;
reg [2:0] bitCnt;
reg [1:0] mState;
reg [3:0] halfCnt;
reg sampledBit;
wire asMaster;
wire asSlave;
wire selNow;
wire faultNow;
wire sckRise;
wire nssFall;
wire slvRise;
wire halfDone;
wire masterStart;
wire slaveLoad;
wire txLoad;
wire mDone;
wire sDone;
wire byteDone;
wire [7:0] byteVal;
wire rxInReady;
wire rxPush;
wire collideNow;

// Pins from the far side pass two flip-flops before any use
always @(posedge clk) begin
	if (rst) begin
		sckMeta <= 1'b0;
		sckSync <= 1'b0;
		sckPrev <= 1'b0;
		mosiMeta <= 1'b0;
		mosiSync <= 1'b0;
		misoMeta <= 1'b0;
		misoSync <= 1'b0;
		nssMeta <= 1'b1;
		nssSync <= 1'b1;
		nssPrev <= 1'b1;
	end else begin
		sckMeta <= sckIn;
		sckSync <= sckMeta;
		sckPrev <= sckSync;
		mosiMeta <= mosiIn;
		mosiSync <= mosiMeta;
		misoMeta <= misoIn;
		misoSync <= misoMeta;
		nssMeta <= nssIn;
		nssSync <= nssMeta;
		nssPrev <= nssSync;
	end
end

// Role and event decode
assign asMaster = serialCtrlEnable & masterEnableFlag;
assign asSlave = serialCtrlEnable & ~masterEnableFlag;
assign selNow = slaveSelected(selectModeField, nssSync);
assign faultNow = asMaster & (selectModeField == `SMS_MODE_MULTI) &
	~nssSync;
assign sckRise = sckSync & ~sckPrev;
assign nssFall = nssPrev & ~nssSync;
// Unselected four-wire slave never sees the clock
assign slvRise = asSlave & selNow & sckRise;
assign halfDone = (halfCnt == HALF_LAST);

// Transfer start: master waits for room in the receive FIFO
assign masterStart = asMaster & ~faultNow & (mState == M_IDLE) &
	txBufFull & rxInReady;
// Reload waits a cycle when a clock edge or select fall lands with it
assign slaveLoad = asSlave & txBufFull & shiftEmpty &
	(bitCnt == 3'h0) & ~slvRise & ~nssFall;
assign txLoad = masterStart | slaveLoad;

// Byte completion, new bit enters at the bottom
assign mDone = (mState == M_HIGH) & halfDone &
	(bitCnt == `SMS_LAST_BIT);
assign sDone = slvRise & (bitCnt == `SMS_LAST_BIT);
assign byteDone = mDone | sDone;
assign byteVal = mDone ? {shiftReg[6:0], sampledBit} :
	{shiftReg[6:0], mosiSync};
assign rxPush = byteDone & rxInReady;
// Writes that find the buffer still occupied are dropped
assign collideNow = serialDataWrite & txBufFull & ~txLoad;

// Control bits; a mode fault overrides the enable and master bits of a same-cycle write
always @(posedge clk) begin
	if (rst) begin
		serialCtrlEnable <= `SMS_ENABLE_RESET;
		masterEnableFlag <= `SMS_MASTER_RESET;
		selectModeField <= `SMS_MODE_RESET;
	end else begin
		if (ctrlWrite) begin
			serialCtrlEnable <= ctrlWrEnable;
			masterEnableFlag <= ctrlWrMaster;
			selectModeField <= ctrlWrMode;
		end
		if (faultNow) begin
			serialCtrlEnable <= 1'b0;
			masterEnableFlag <= 1'b0;
		end
	end
end

// Sticky status flags, hardware only ever sets them
always @(posedge clk) begin
	if (rst) begin
		transferDoneFlag <= 1'b0;
		writeCollisionFlag <= 1'b0;
		modeFaultFlag <= 1'b0;
		overrunFlag <= 1'b0;
	end else begin
		transferDoneFlag <= flagNext(transferDoneFlag, byteDone,
			clearDone);
		writeCollisionFlag <= flagNext(writeCollisionFlag, collideNow,
			clearCollision);
		modeFaultFlag <= flagNext(modeFaultFlag, faultNow,
			clearFault);
		overrunFlag <= flagNext(overrunFlag, byteDone & ~rxInReady,
			clearOverrun);
	end
end

// Transmit holding buffer
always @(posedge clk) begin
	if (rst) begin
		txBuf <= 8'h00;
		txBufFull <= 1'b0;
	end else begin
		if (serialDataWrite && (!txBufFull || txLoad)) begin
			txBuf <= serialDataByte;
			txBufFull <= 1'b1;
		end else if (txLoad || !serialCtrlEnable) begin
			txBufFull <= 1'b0;
		end
	end
end

// Shifter, bit counter and master clock sequencer
always @(posedge clk) begin
	if (rst) begin
		shiftReg <= 8'h00;
		shiftEmpty <= 1'b1;
		bitCnt <= 3'h0;
		mState <= M_IDLE;
		halfCnt <= 4'h0;
		sampledBit <= 1'b0;
		sckOut <= 1'b0;
		mosiOut <= 1'b0;
	end else if (!serialCtrlEnable || faultNow) begin
		// Disable or fault aborts and rearms the bit counter
		bitCnt <= 3'h0;
		mState <= M_IDLE;
		halfCnt <= 4'h0;
		sckOut <= 1'b0;
		shiftEmpty <= 1'b1;
	end else if (asMaster) begin
		case (mState)
		M_IDLE: begin
			sckOut <= 1'b0;
			if (masterStart) begin
				shiftReg <= txBuf;
				shiftEmpty <= 1'b0;
				mosiOut <= txBuf[7];
				bitCnt <= 3'h0;
				halfCnt <= 4'h0;
				mState <= M_LOW;
			end
		end
		M_LOW: begin
			if (halfDone) begin
				sckOut <= 1'b1;
				sampledBit <= misoSync;
				halfCnt <= 4'h0;
				mState <= M_HIGH;
			end else begin
				halfCnt <= halfCnt + 4'h1;
			end
		end
		M_HIGH: begin
			if (halfDone) begin
				sckOut <= 1'b0;
				halfCnt <= 4'h0;
				shiftReg <= {shiftReg[6:0], sampledBit};
				mosiOut <= shiftReg[6];
				if (bitCnt == `SMS_LAST_BIT) begin
					shiftEmpty <= 1'b1;
					bitCnt <= 3'h0; // Rearm so busy drops
					mState <= M_IDLE;
				end else begin
					bitCnt <= bitCnt + 3'h1;
					mState <= M_LOW;
				end
			end else begin
				halfCnt <= halfCnt + 4'h1;
			end
		end
		default: begin
			mState <= M_IDLE;
		end
		endcase
	end else begin
		// Slave: falling select restarts the byte in four-wire mode
		mState <= M_IDLE;
		sckOut <= 1'b0;
		if ((selectModeField == `SMS_MODE_MULTI) && nssFall) begin
			bitCnt <= 3'h0;
		end else if (slvRise) begin
			bitCnt <= bitCnt + 3'h1;
			shiftReg <= {shiftReg[6:0], mosiSync};
			shiftEmpty <= 1'b0;
			if (sDone) begin
				shiftEmpty <= 1'b1;
			end
		end else if (slaveLoad) begin
			shiftReg <= txBuf;
			shiftEmpty <= 1'b0;
		end
	end
end

// Pin drivers and status; enables are low while driving
always @(posedge clk) begin
	if (rst) begin
		sckOeN <= 1'b1;
		mosiOeN <= 1'b1;
		misoOut <= 1'b0;
		misoOeN <= 1'b1;
		nssOut <= 1'b1;
		nssOeN <= 1'b1;
		nssPinMapped <= 1'b1;
		busy <= 1'b0;
	end else begin
		sckOeN <= ~asMaster;
		mosiOeN <= ~asMaster;
		misoOut <= shiftReg[7];
		misoOeN <= ~(asSlave & selNow);
		nssOut <= selectModeField[`SMS_MODE_LO_BIT];
		nssOeN <= ~selectModeField[`SMS_MODE_HI_BIT];
		nssPinMapped <= (selectModeField != `SMS_MODE_3WIRE);
		busy <= (mState != M_IDLE) | (bitCnt != 3'h0);
	end
end

// Receive buffer; a full buffer stalls the master before it starts
sms_fifo #(
	.WIDTH(`SMS_FIFO_W),
	.DEPTH(`SMS_FIFO_DEPTH),
	.AW(`SMS_FIFO_AW)
) rxFifo (
	.clk(clk),
	.rst(rst),
	.inValid(rxPush),
	.inData(byteVal),
	.inReady(rxInReady),
	.outValid(rxValid),
	.outData(rxByte),
	.outReady(rxReady)
);

endmodule

// ### sms_ctrl_props.sv
// Purpose: port assertions for the serial controller
// Assumes: one clock, rst synchronous active high
// Notes: bound into every sms_ctrl instance
`timescale 1ns/1ns
module sms_ctrl_props (
	input wire clk,
	input wire rst,
	input wire nssIn,
	input wire clearDone,
	input wire clearFault,
	input wire sckOut,
	input wire misoOeN,
	input wire nssOut,
	input wire nssOeN,
	input wire nssPinMapped,
	input wire serialCtrlEnable,
	input wire masterEnableFlag,
	input wire [1:0] selectModeField,
	input wire transferDoneFlag,
	input wire modeFaultFlag,
	input wire busy
);
	reg [3:0] rises;
	// Clock pulses of one master byte; restarts with each byte
	always @(posedge clk) begin
		if (rst || $rose(busy))
			rises <= 4'h0;
		else if ($rose(sckOut))
			rises <= rises + 4'h1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_start;
		$rose(busy) && masterEnableFlag;
	endsequence
	sequence s_end;
		$fell(busy) && masterEnableFlag;
	endsequence
	a_eight_pulses: assert property (s_end |-> rises == 4'h8)
		else $error("master byte without eight clock pulses");
	a_byte_time: assert property (s_start |-> ##[60:80] transferDoneFlag)
		else $error("done flag late after master start");
	a_sck_idle: assert property (!busy [*2] |-> !sckOut)
		else $error("serial clock moves while idle");
	a_fault_set: assert property ((masterEnableFlag && !nssIn &&
		selectModeField == 2'h1) [*3] |-> ##[0:3] (modeFaultFlag &&
		!masterEnableFlag && !serialCtrlEnable))
		else $error("low select did not cause mode fault");
	a_nss_drive: assert property (selectModeField[1] &&
		$stable(selectModeField) |-> !nssOeN && nssOut == selectModeField[0])
		else $error("select output does not follow mode");
	a_pin_map: assert property ($stable(selectModeField) |->
		nssPinMapped == (selectModeField != 2'h0))
		else $error("select pin mapping wrong");
	a_miso_off: assert property (!serialCtrlEnable &&
		!$past(serialCtrlEnable) |-> misoOeN)
		else $error("slave out driven while disabled");
	a_done_kept: assert property (transferDoneFlag && !clearDone &&
		!$past(clearDone) |=> transferDoneFlag)
		else $error("done flag dropped without clear");
	a_fault_kept: assert property (modeFaultFlag && !clearFault &&
		!$past(clearFault) |=> modeFaultFlag)
		else $error("fault flag dropped without clear");
endmodule
bind sms_ctrl sms_ctrl_props i_sms_ctrl_props (.clk(clk), .rst(rst),
	.nssIn(nssIn), .clearDone(clearDone), .clearFault(clearFault),
	.sckOut(sckOut), .misoOeN(misoOeN), .nssOut(nssOut), .nssOeN(nssOeN),
	.nssPinMapped(nssPinMapped), .serialCtrlEnable(serialCtrlEnable),
	.masterEnableFlag(masterEnableFlag), .selectModeField(selectModeField),
	.transferDoneFlag(transferDoneFlag), .modeFaultFlag(modeFaultFlag),
	.busy(busy));

// ### sms_slave_model.sv
// Purpose: behavioural slave on the far side of the link
// Assumes: link mode 0, data taken on the rising serial clock
// Notes: spent bits are refilled inverted so stale data never matches
`timescale 1ns/1ns
module sms_slave_model (
	input wire sck,
	input wire mosi,
	input wire load,
	input wire [7:0] reply,
	output wire miso,
	output reg [7:0] heard,
	output reg [3:0] pulses
);
	reg [7:0] sr;
	assign miso = sr[7];
	// Capture on rise, first bit is the top one; load restarts the count
	always @(posedge sck or posedge load) begin
		if (load)
			pulses <= 4'h0;
		else begin
			heard <= {heard[6:0], mosi};
			pulses <= pulses + 4'h1;
		end
	end
	// Reply set up before each frame, shifted after each fall
	always @(negedge sck or posedge load) begin
		if (load)
			sr <= reply;
		else
			sr <= {sr[6:0], ~sr[7]};
	end
endmodule

// ### sms_ctrl_tb_top.sv
// Purpose: self-checking bench for the serial controller
// Assumes: 100 MHz clock, link clock of 80 ns driven by the bench
// Notes: random bytes from a shift register seeded with 80
`timescale 1ns/1ns
module sms_ctrl_tb_top;
	reg clk, rst, ctrlWrite, ctrlWrEnable, ctrlWrMaster, serialDataWrite;
	reg clearDone, clearCollision, clearFault, clearOverrun, rxReady;
	reg tbSck, tbMosi, tbNss, load;
	reg [1:0] ctrlWrMode;
	reg [7:0] serialDataByte, reply, lf, got;
	wire [7:0] rxByte, heard;
	wire [3:0] pulses;
	wire [1:0] selectModeField;
	wire rxValid, sckOut, sckOeN, mosiOut, mosiOeN, misoOut, misoOeN;
	wire nssOut, nssOeN, nssPinMapped, serialCtrlEnable, masterEnableFlag;
	wire transferDoneFlag, writeCollisionFlag, modeFaultFlag, overrunFlag;
	wire busy, txBufFull, partMiso;
	// Pin levels from whichever side enables its driver
	wire sckIn = sckOeN ? tbSck : sckOut;
	wire mosiIn = mosiOeN ? tbMosi : mosiOut;
	wire misoIn = misoOeN ? partMiso : misoOut;
	wire nssIn = nssOeN ? tbNss : nssOut;
	int n_mismatch, n_checks, i, k;
	reg [7:0] q[$];
	sms_ctrl i_sms_ctrl (.clk(clk), .rst(rst), .ctrlWrite(ctrlWrite),
		.ctrlWrEnable(ctrlWrEnable), .ctrlWrMaster(ctrlWrMaster),
		.ctrlWrMode(ctrlWrMode), .serialDataWrite(serialDataWrite),
		.serialDataByte(serialDataByte), .clearDone(clearDone),
		.clearCollision(clearCollision), .clearFault(clearFault),
		.clearOverrun(clearOverrun), .rxByte(rxByte), .rxValid(rxValid),
		.rxReady(rxReady), .sckIn(sckIn), .sckOut(sckOut), .sckOeN(sckOeN),
		.mosiIn(mosiIn), .mosiOut(mosiOut), .mosiOeN(mosiOeN),
		.misoIn(misoIn), .misoOut(misoOut), .misoOeN(misoOeN),
		.nssIn(nssIn), .nssOut(nssOut), .nssOeN(nssOeN),
		.nssPinMapped(nssPinMapped), .serialCtrlEnable(serialCtrlEnable),
		.masterEnableFlag(masterEnableFlag),
		.selectModeField(selectModeField),
		.transferDoneFlag(transferDoneFlag),
		.writeCollisionFlag(writeCollisionFlag),
		.modeFaultFlag(modeFaultFlag), .overrunFlag(overrunFlag),
		.busy(busy), .txBufFull(txBufFull));
	sms_slave_model i_sms_slave_model (.sck(sckIn), .mosi(mosiIn),
		.load(load), .reply(reply), .miso(partMiso), .heard(heard),
		.pulses(pulses));
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	function [7:0] nxt(input [7:0] v);
		nxt = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task chk(input string nm, input [7:0] seen, input [7:0] want);
		n_checks++;
		if (seen !== want) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, want, seen);
		end
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// A wait that ran out ends the run
	task bound(input int n);
		if (n >= 300) begin
			n_mismatch++;
			give_verdict;
		end
	endtask
	task ctrl(input en, ms, input [1:0] md);
		@(posedge clk);
		ctrlWrite <= 1'h1;
		ctrlWrEnable <= en;
		ctrlWrMaster <= ms;
		ctrlWrMode <= md;
		@(posedge clk);
		ctrlWrite <= 1'h0;
		tick(3);
	endtask
	task wr(input [7:0] b);
		@(posedge clk);
		serialDataWrite <= 1'h1;
		serialDataByte <= b;
		@(posedge clk);
		serialDataWrite <= 1'h0;
		tick(2);
	endtask
	task pop;
		@(posedge clk);
		rxReady <= 1'h1;
		@(posedge clk);
		rxReady <= 1'h0;
		tick(2);
	endtask
	// Busy rises only two edges after the write lands
	task idle;
		tick(2);
		for (k = 0; k < 300 && (busy || txBufFull); k++) tick(1);
		bound(k);
	endtask
	// Bench acts as master: 80 ns link clock, still between frames
	task frame(input [7:0] v);
		int b;
		for (b = 7; b >= 0; b--) begin
			tbMosi <= v[b];
			tick(4);
			tbSck <= 1'h1;
			got = {got[6:0], misoOut};
			tick(4);
			tbSck <= 1'h0;
		end
	endtask
	initial begin
		{ctrlWrite, ctrlWrEnable, ctrlWrMaster, serialDataWrite} = 4'h0;
		{clearDone, clearCollision, clearFault, clearOverrun} = 4'h0;
		{rxReady, tbSck, tbMosi, load, tbNss, rst} = 6'h03;
		ctrlWrMode = 2'h0;
		serialDataByte = 8'h00;
		reply = 8'h00;
		lf = 8'h50;
		n_mismatch = 0;
		n_checks = 0;
		tick(12);
		rst <= 1'h0;
		tick(2);
		chk("mode", selectModeField, 2'h1);
		chk("mapped", nssPinMapped, 1'h1);
		chk("misoOeN", misoOeN, 1'h1);
		ctrl(1'h1, 1'h1, 2'h0);
		chk("mosiOeN", mosiOeN, 1'h0);
		chk("sckOeN", sckOeN, 1'h0);
		chk("mapped", nssPinMapped, 1'h0);
		// Nine bytes with reads held off: the ninth must wait for room
		for (i = 0; i < 9; i++) begin
			lf = nxt(lf);
			q.push_back(lf);
			@(posedge clk);
			reply <= lf;
			load <= 1'h1;
			@(posedge clk);
			load <= 1'h0;
			wr(~lf);
			if (i == 8) begin
				tick(100);
				chk("stalled", txBufFull, 1'h1);
				chk("overrun", overrunFlag, 1'h0);
			end else begin
				idle;
				tick(2);
				chk("heard", heard, ~lf);
				chk("pulses", pulses, 8'h8);
				chk("done", transferDoneFlag, 1'h1);
			end
		end
		// Drain; the waiting byte goes out once a slot frees
		for (i = 0; i < 9; i++) begin
			for (k = 0; k < 300 && rxValid !== 1'h1; k++) tick(1);
			bound(k);
			chk("rxByte", rxByte, q.pop_front());
			pop;
		end
		chk("empty", rxValid, 1'h0);
		@(posedge clk);
		clearDone <= 1'h1;
		@(posedge clk);
		clearDone <= 1'h0;
		tick(2);
		chk("doneClr", transferDoneFlag, 1'h0);
		// Three writes on consecutive edges: the third collides
		@(posedge clk);
		serialDataWrite <= 1'h1;
		tick(3);
		serialDataWrite <= 1'h0;
		tick(2);
		chk("collision", writeCollisionFlag, 1'h1);
		@(posedge clk);
		clearCollision <= 1'h1;
		@(posedge clk);
		clearCollision <= 1'h0;
		tick(2);
		chk("collisionClr", writeCollisionFlag, 1'h0);
		idle;
		rxReady <= 1'h1;
		tick(90);
		rxReady <= 1'h0;
		ctrl(1'h1, 1'h1, 2'h1);
		@(posedge clk);
		tbNss <= 1'h0;
		tick(6);
		chk("fault", modeFaultFlag, 1'h1);
		chk("master", masterEnableFlag, 1'h0);
		chk("enable", serialCtrlEnable, 1'h0);
		@(posedge clk);
		tbNss <= 1'h1;
		tick(4);
		chk("faultKept", modeFaultFlag, 1'h1);
		@(posedge clk);
		clearFault <= 1'h1;
		@(posedge clk);
		clearFault <= 1'h0;
		tick(2);
		chk("faultClr", modeFaultFlag, 0);
		for (i = 2; i < 4; i++) begin
			ctrl(1'h1, 1'h1, i[1:0]);
			chk("nssOeN", nssOeN, 1'h0);
			chk("nssOut", nssOut, i[0]);
			chk("mapped", nssPinMapped, 1'h1);
		end
		ctrl(1'h1, 1'h0, 2'h0);
		lf = nxt(lf);
		wr(lf);
		chk("misoOeN", misoOeN, 1'h0);
		frame(nxt(lf));
		chk("slaveTx", got, lf);
		for (k = 0; k < 300 && rxValid !== 1'h1; k++) tick(1);
		bound(k);
		chk("slaveRx", rxByte, nxt(lf));
		pop;
		ctrl(1'h1, 1'h0, 2'h1);
		chk("misoOeN", misoOeN, 1'h1);
		frame(lf);
		tick(10);
		chk("ignored", rxValid, 1'h0);
		@(posedge clk);
		tbNss <= 1'h0;
		tick(4);
		chk("selected", misoOeN, 1'h0);
		ctrl(1'h0, 1'h0, 2'h1);
		chk("misoOff", misoOeN, 1'h1);
		give_verdict;
	end
endmodule
